// File: hw/sfrtp_slice.sv
// Special function register slice: analog, edge, timer high bits and timer-0 mode
`timescale 1ns/100ps
`include "sfrtp_map.svh"
module sfrtp_slice (
	input  wire logic                 clk_sys,         // 10 MHz instruction clock
	input  wire logic                 reset,           // Synchronous, active high
	input  wire logic                 sfrWrEn,         // Data-space write strobe
	input  wire logic                 sfrRdEn,         // Data-space read strobe
	input  wire logic [7:0]           sfrAddr,         // Data-space address
	input  wire logic [7:0]           sfrWrData,       // Write data
	input  wire logic                 t0ModeWrInstr,   // Timer-0 mode write instruction
	input  wire logic                 t0ModeRdInstr,   // Timer0_mode_read_instr
	input  wire logic [1:0]           timer1Count98,   // Live timer-1 bits 9:8
	input  wire logic [1:0]           timer2Count98,   // Live timer-2 bits 9:8
	input  wire logic [1:0]           timer3Count98,   // Live timer-3 bits 9:8
	input  wire logic                 timer3Underflow, // Timer-3 underflow pulse
	input  wire logic                 wdtIrqMode,      // Watchdog in interrupt mode
	output logic      [7:0]           sfrRdData_r,     // Read data, one cycle after strobe
	output logic      [4:0]           portaAnalogOnly_r, // Port A analog-only
	output logic      [2:0]           portbAnalogOnly_r, // Port B 2:0 analog-only
	output sfrtp_pkg::sfrtp_trim_t    trim_r,          // Converter offset trim
	output logic      [1:0]           extIrqPinRoute_r, // Bit1 irq1, bit0 irq0
	output logic      [1:0]           extIrq0EdgeSel_r, // Irq0 edge code
	output logic      [1:0]           extIrq1EdgeSel_r, // Irq1 edge code
	output logic      [1:0]           extIrq0Edges_r,  // {falling, rising} enables irq0
	output logic      [1:0]           extIrq1Edges_r,  // {falling, rising} enables irq1
	output logic      [1:0]           timer1Reload98_r, // Timer-1 reload bits 9:8
	output logic      [1:0]           timer2Reload98_r, // Timer-2 reload bits 9:8
	output logic      [1:0]           timer3Reload98_r, // Timer-3 reload bits 9:8
	output logic      [7:0]           dutyUpper_r,     // {d4,d3,d2,d1} upper pairs
	output logic                      comparatorOn_r,  // Comparator enable
	output logic                      freqMeasureOn_r, // Measurement enable
	output logic      [13:0]          measPadOneHot_r, // PB5..PB0, PA7..PA0
	output logic                      timer3UnderflowFlag_r, // Sticky flag
	output logic                      timer3IrqReq_r,  // Gated interrupt request
	output sfrtp_pkg::sfrtp_t0mode_t  t0Mode_r,        // Timer-0 mode register
	output logic      [3:0]           prescaleLog2_r,  // Division is 2**this
	output sfrtp_pkg::sfrtp_src_t     timer0Source_r   // Timer-0 clock source
);
	import sfrtp_pkg::*;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Write strobe for one data address
	function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] r);
		hit = en && (a == r);
	endfunction

	// Edge code to {falling, rising} enables; reserved code enables nothing
	function automatic logic [1:0] edgeEnables(input logic [1:0] code);
		unique case (code)
			`SFRTP_EDGE_RISE:     edgeEnables = 2'h1;
			`SFRTP_EDGE_FALL:     edgeEnables = 2'h2;
			`SFRTP_EDGE_BOTH:     edgeEnables = 2'h3;
			`SFRTP_EDGE_RESERVED: edgeEnables = 2'h0;
		endcase
	endfunction

	logic [7:0] hiByte;
	logic [5:0] hi3Byte;
	logic       hiWrEn;
	logic [0:0] hiWrSel;
	logic       wrTrim;
	logic       wrEdge;
	logic       wrFreq;
	logic [3:0] padSel_r;
	logic [3:0] prescaleLog2_nxt;
	logic       t0IrqEnable_r;

	assign hiWrEn  = hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_TIMER_PWM_HIGH_BITS) ||
	                 hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_TIMER3_PWM_HIGH_BITS);
	assign hiWrSel = hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_TIMER3_PWM_HIGH_BITS) ? 1'b1 : 1'b0;
	assign wrTrim  = hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_TRIM);
	assign wrEdge  = hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_EDGE);
	assign wrFreq  = hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_FREQ);

	// Upper-pair store, left unreset
	sfrtp_hibits_mem uHiMem (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.wrEn      (hiWrEn),
		.wrSel     (hiWrSel),
		.wrData    (sfrWrData),
		.hiByte_r  (hiByte),
		.hi3Byte_r (hi3Byte)
	);

	// ----------------------------------------
	// Analog pin selects
	// ----------------------------------------
	// High bit set disables the digital buffer of that pin
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{portbAnalogOnly_r, portaAnalogOnly_r} <= `SFRTP_RST_ANALOG_PIN;
		end else if (hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_ANALOG_PIN)) begin
			{portbAnalogOnly_r, portaAnalogOnly_r} <= sfrWrData;
		end
	end

	// Converter offset trim, top two positions dropped
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			trim_r <= `SFRTP_RST_TRIM;
		end else if (wrTrim) begin
			trim_r <= sfrWrData[5:0];
		end
	end

	// ----------------------------------------
	// External interrupt routing and edges
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{extIrqPinRoute_r, extIrq1EdgeSel_r, extIrq0EdgeSel_r} <= `SFRTP_RST_EDGE;
		end else if (wrEdge) begin
			{extIrqPinRoute_r, extIrq1EdgeSel_r, extIrq0EdgeSel_r} <= sfrWrData[5:0];
		end
	end

	// Decoded edge enables registered so outputs come from flops
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			// Both routes reset clear, so no edge may count yet
			extIrq0Edges_r <= `SFRTP_RST_EDGE_EN;
			extIrq1Edges_r <= `SFRTP_RST_EDGE_EN;
		end else begin
			// Pin not routed means no edge ever counts
			extIrq0Edges_r <= extIrqPinRoute_r[0] ? edgeEnables(extIrq0EdgeSel_r) : 2'h0;
			extIrq1Edges_r <= extIrqPinRoute_r[1] ? edgeEnables(extIrq1EdgeSel_r) : 2'h0;
		end
	end

	// ----------------------------------------
	// Timer reload and duty upper pairs
	// ----------------------------------------
	// Fanned out from the store; registered again to keep outputs on flops
	always_ff @(posedge clk_sys) begin
		timer2Reload98_r <= hiByte[7:6];
		timer1Reload98_r <= hiByte[5:4];
		timer3Reload98_r <= hi3Byte[5:4];
		dutyUpper_r      <= {hi3Byte[3:0], hiByte[3:0]};
	end

	// ----------------------------------------
	// Comparator and measurement function
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			comparatorOn_r <= `SFRTP_RST_ANALOG_BLOCK_ENABLE;
		end else if (hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_ANALOG_BLOCK_ENABLE)) begin
			comparatorOn_r <= sfrWrData[`SFRTP_BIT_EN7];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{freqMeasureOn_r, padSel_r} <= `SFRTP_RST_FREQ;
		end else if (wrFreq) begin
			{freqMeasureOn_r, padSel_r} <= {sfrWrData[`SFRTP_BIT_EN7], sfrWrData[3:0]};
		end
	end

	// One-hot pad; codes above port B 5 select nothing
	always_ff @(posedge clk_sys) begin
		if (reset || !freqMeasureOn_r || padSel_r > `SFRTP_PAD_PB_LAST) begin
			measPadOneHot_r <= `SFRTP_MEAS_NONE;
		end else begin
			measPadOneHot_r <= 14'(1) << padSel_r;
		end
	end

	// ----------------------------------------
	// Timer-3 underflow flag and request
	// ----------------------------------------
	// Set wins over a same-cycle software clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			timer3UnderflowFlag_r <= 1'b0;
			timer3IrqReq_r        <= 1'b0;
		end else begin
			if (timer3Underflow) begin
				timer3UnderflowFlag_r <= 1'b1;
			end else if (hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_T3IRQ)) begin
				timer3UnderflowFlag_r <= sfrWrData[`SFRTP_BIT_T3FLAG];
			end
			timer3IrqReq_r <= timer3UnderflowFlag_r && t0IrqEnable_r;
		end
	end

	// Timer-3 interrupt enable bit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			t0IrqEnable_r <= 1'b0;
		end else if (hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_T3IRQ)) begin
			t0IrqEnable_r <= sfrWrData[`SFRTP_BIT_T3EN];
		end
	end

	// ----------------------------------------
	// Timer-0 mode and prescaler
	// ----------------------------------------
	// Only the dedicated instruction writes it; no data address
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			t0Mode_r <= `SFRTP_RST_T0MODE;
		end else if (t0ModeWrInstr) begin
			t0Mode_r <= sfrWrData;
		end
	end

	// Division exponent per assignment and watchdog mode
	always_comb begin
		if (t0Mode_r.toWatchdog && !wdtIrqMode) begin
			prescaleLog2_nxt = {1'b0, t0Mode_r.rateCode};
		end else begin
			prescaleLog2_nxt = {1'b0, t0Mode_r.rateCode} + 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prescaleLog2_r <= `SFRTP_DIV_MAX_LOG;
			timer0Source_r <= SRC_INSTR;
		end else begin
			prescaleLog2_r <= prescaleLog2_nxt;
			// Source choice
			if (!t0Mode_r.sourceSel) begin
				timer0Source_r <= SRC_INSTR;
			end else if (t0Mode_r.lowOscSel) begin
				timer0Source_r <= SRC_LOW_OSC;
			end else begin
				timer0Source_r <= SRC_EXT_PIN;
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Live counter pairs read back instead of reloads zeros fill gaps
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sfrRdData_r <= 8'h00;
		end else if (t0ModeRdInstr) begin
			sfrRdData_r <= t0Mode_r;
		end else if (sfrRdEn) begin
			unique case (sfrAddr)
				`SFRTP_ADDR_ANALOG_PIN: sfrRdData_r <= {portbAnalogOnly_r, portaAnalogOnly_r};
				`SFRTP_ADDR_TRIM:  sfrRdData_r <= {2'h0, trim_r};
				`SFRTP_ADDR_EDGE:  sfrRdData_r <= {2'h0, extIrqPinRoute_r,
				                                   extIrq1EdgeSel_r, extIrq0EdgeSel_r};
				`SFRTP_ADDR_TIMER_PWM_HIGH_BITS:  sfrRdData_r <= {timer2Count98, timer1Count98, hiByte[3:0]};
				`SFRTP_ADDR_ANALOG_BLOCK_ENABLE: sfrRdData_r <= {comparatorOn_r, 7'h00};
				`SFRTP_ADDR_FREQ:  sfrRdData_r <= {freqMeasureOn_r, 3'h0, padSel_r};
				`SFRTP_ADDR_TIMER3_PWM_HIGH_BITS: sfrRdData_r <= {2'h0, timer3Count98, hi3Byte[3:0]};
				`SFRTP_ADDR_T3IRQ: sfrRdData_r <= {3'h0, timer3UnderflowFlag_r, 3'h0,
				                                   t0IrqEnable_r};
				default:           sfrRdData_r <= 8'h00;
			endcase
		end else begin
			sfrRdData_r <= 8'h00;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	flag_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
		timer3Underflow |=> timer3UnderflowFlag_r) else $error("underflow flag not set");
	irq_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
		timer3IrqReq_r |-> $past(timer3UnderflowFlag_r) && $past(t0IrqEnable_r))
		else $error("irq request without enable");
	comp_enable_a: assert property (@(posedge clk_sys) disable iff (reset)
		hit(sfrWrEn, sfrAddr, `SFRTP_ADDR_ANALOG_BLOCK_ENABLE) |=> comparatorOn_r == $past(sfrWrData[`SFRTP_BIT_EN7]))
		else $error("comparator enable wrong");
	pad_range_a: assert property (@(posedge clk_sys) disable iff (reset)
		(freqMeasureOn_r && padSel_r <= `SFRTP_PAD_PB_LAST) |=> $onehot(measPadOneHot_r))
		else $error("pad select not one-hot");
	rate_timer0_a: assert property (@(posedge clk_sys) disable iff (reset)
		!t0Mode_r.toWatchdog ##1 !t0Mode_r.toWatchdog && $stable(t0Mode_r)
		|-> prescaleLog2_r == {1'b0, t0Mode_r.rateCode} + 4'h1)
		else $error("timer-0 rate wrong");
	rate_wdt_rst_a: assert property (@(posedge clk_sys) disable iff (reset)
		(t0Mode_r.toWatchdog && !wdtIrqMode) ##1 $stable(t0Mode_r) && !wdtIrqMode
		|-> prescaleLog2_r == {1'b0, t0Mode_r.rateCode})
		else $error("watchdog reset rate wrong");
	t3_readback_a: assert property (@(posedge clk_sys) disable iff (reset)
		(sfrRdEn && !t0ModeRdInstr && sfrAddr == `SFRTP_ADDR_TIMER3_PWM_HIGH_BITS)
		|=> sfrRdData_r[5:4] == $past(timer3Count98))
		else $error("timer-3 readback wrong");
	edge_route_a: assert property (@(posedge clk_sys) disable iff (reset)
		!extIrqPinRoute_r[0] |=> extIrq0Edges_r == 2'h0)
		else $error("unrouted pin has edges");
endmodule

// File: hw/sfrtp_map.svh
// Register offsets, field positions and reset values of the SFR slice
`ifndef SFRTP_MAP_SVH
`define SFRTP_MAP_SVH
`define SFRTP_ADDR_ANALOG_PIN   8'h16
`define SFRTP_ADDR_TRIM         8'h17
`define SFRTP_ADDR_EDGE         8'h18
`define SFRTP_ADDR_TIMER_PWM_HIGH_BITS         8'h19
`define SFRTP_ADDR_ANALOG_BLOCK_ENABLE        8'h1A
`define SFRTP_ADDR_FREQ         8'h1B
`define SFRTP_ADDR_TIMER3_PWM_HIGH_BITS        8'h1C
`define SFRTP_ADDR_T3IRQ        8'h1F
`define SFRTP_RST_ANALOG_PIN    8'h00
`define SFRTP_RST_TRIM          6'h00
`define SFRTP_RST_EDGE          6'h05
`define SFRTP_RST_EDGE_EN       2'h0
`define SFRTP_RST_ANALOG_BLOCK_ENABLE         1'h0
`define SFRTP_RST_FREQ          5'h00
`define SFRTP_RST_T0MODE        8'h3F
`define SFRTP_BIT_EN7           7
`define SFRTP_BIT_T3FLAG        4
`define SFRTP_BIT_T3EN          0
`define SFRTP_EDGE_RESERVED     2'h0
`define SFRTP_EDGE_RISE         2'h1
`define SFRTP_EDGE_FALL         2'h2
`define SFRTP_EDGE_BOTH         2'h3
`define SFRTP_PAD_PA_LAST       4'h7
`define SFRTP_PAD_PB_LAST       4'hD
`define SFRTP_PAD_PB_BASE       4'h8
`define SFRTP_MEAS_NONE         14'h0000
`define SFRTP_DIV_MAX_LOG       4'h8
`endif

// File: hw/sfrtp_pkg.sv
// Types shared by the SFR slice
package sfrtp_pkg;
	// Timer-0 mode register layout
	typedef struct packed {
		logic       lowOscSel;   // Low-frequency oscillator as ext source
		logic       general6;    // General purpose bit
		logic       sourceSel;   // 0 instruction clock, 1 external
		logic       extEdgeSel;  // External edge polarity
		logic       toWatchdog;  // Prescaler assignment
		logic [2:0] rateCode;    // Prescaler rate code
	} sfrtp_t0mode_t;
	// Trim settings as seen by the converter
	typedef struct packed {
		logic       direction;   // 1 increase, 0 decrease
		logic [4:0] magnitude;   // 0 .. 12.5 mV
	} sfrtp_trim_t;
	// Timer-0 clock source choice
	typedef enum logic [1:0] {SRC_INSTR, SRC_EXT_PIN, SRC_LOW_OSC} sfrtp_src_t;
endpackage

// File: hw/sfrtp_hibits_mem.sv
// Small register store for timer reload and duty upper pairs
`timescale 1ns/100ps
module sfrtp_hibits_mem (
	input  wire logic       clk_sys,   // System clock
	input  wire logic       reset,     // Synchronous reset, not applied
	input  wire logic       wrEn,      // Write strobe
	input  wire logic [0:0] wrSel,     // 0 first high byte, 1 timer-3 byte
	input  wire logic [7:0] wrData,    // Write data
	output logic      [7:0] hiByte_r,  // Stored first high byte
	output logic      [5:0] hi3Byte_r  // Stored timer-3 high byte
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Unknown at reset, so reset is deliberately ignored
	always_ff @(posedge clk_sys) begin
		if (wrEn && !wrSel[0]) begin
			hiByte_r <= wrData;
		end
		if (wrEn && wrSel[0]) begin
			hi3Byte_r <= wrData[5:0];  // Upper two positions ignored
		end
	end
endmodule

// File: tb/sfrtp_slice_tb.sv
// Self-checking testbench for the SFR slice
`timescale 1ns/100ps
module sfrtp_slice_tb;
	import sfrtp_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic                clk_sys, reset, sfrWrEn, sfrRdEn, t0ModeWrInstr, t0ModeRdInstr;
	logic                timer3Underflow, wdtIrqMode;
	logic [7:0]          sfrAddr, sfrWrData, sfrRdData_r, dutyUpper_r;
	logic [1:0]          timer1Count98, timer2Count98, timer3Count98, extIrqPinRoute_r;
	logic [4:0]          portaAnalogOnly_r;
	logic [2:0]          portbAnalogOnly_r;
	sfrtp_trim_t         trim_r;
	logic [1:0]          extIrq0EdgeSel_r, extIrq1EdgeSel_r, extIrq0Edges_r, extIrq1Edges_r;
	logic [1:0]          timer1Reload98_r, timer2Reload98_r, timer3Reload98_r;
	logic                comparatorOn_r, freqMeasureOn_r, timer3UnderflowFlag_r, timer3IrqReq_r;
	logic [13:0]         measPadOneHot_r;
	sfrtp_t0mode_t       t0Mode_r;
	logic [3:0]          prescaleLog2_r, lg;
	sfrtp_src_t          timer0Source_r, src;
	logic [7:0]          sh [0:31];
	logic [7:0]          shT0, a;
	logic [7:0]          pat [8] = '{8'hFF, 8'h00, 8'hA5, 8'h5A, 8'h8D, 8'h30, 8'hC8, 8'h87};
	int                  fails = 0;
	int                  nChecks = 0;

	sfrtp_slice i_dut (.clk_sys, .reset, .sfrWrEn, .sfrRdEn, .sfrAddr, .sfrWrData,
		.t0ModeWrInstr, .t0ModeRdInstr, .timer1Count98, .timer2Count98, .timer3Count98,
		.timer3Underflow, .wdtIrqMode, .sfrRdData_r, .portaAnalogOnly_r, .portbAnalogOnly_r,
		.trim_r, .extIrqPinRoute_r, .extIrq0EdgeSel_r, .extIrq1EdgeSel_r, .extIrq0Edges_r,
		.extIrq1Edges_r, .timer1Reload98_r, .timer2Reload98_r, .timer3Reload98_r, .dutyUpper_r,
		.comparatorOn_r, .freqMeasureOn_r, .measPadOneHot_r, .timer3UnderflowFlag_r,
		.timer3IrqReq_r, .t0Mode_r, .prescaleLog2_r, .timer0Source_r);

	// 10 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic end_of_test;
		if (fails == 0 && nChecks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		nChecks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Implemented bits of each address; anything else must read zero
	function automatic logic [7:0] mask(input logic [7:0] ad);
		case (ad)
			8'h16, 8'h19: mask = 8'hFF;
			8'h17, 8'h18, 8'h1C: mask = 8'h3F;
			8'h1A: mask = 8'h80;
			8'h1B: mask = 8'h8F;
			8'h1F: mask = 8'h11;
			default: mask = 8'h00;
		endcase
	endfunction

	// High pairs read the live counters, not the stored reload
	function automatic logic [7:0] rdExp(input logic [7:0] ad);
		case (ad)
			8'h19: rdExp = {timer2Count98, timer1Count98, sh[5'h19][3:0]};
			8'h1C: rdExp = {2'h0, timer3Count98, sh[5'h1C][3:0]};
			default: rdExp = sh[ad[4:0]];
		endcase
	endfunction

	// Strobes move only at falling edges and stay a full cycle
	task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic mode);
		@(negedge clk_sys);
		sfrAddr = ad;
		sfrWrData = d;
		if (mode) t0ModeWrInstr = 1'b1;
		else sfrWrEn = 1'b1;
		@(negedge clk_sys);
		sfrWrEn = 1'b0;
		t0ModeWrInstr = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask

	// Read data stands one cycle, then returns to zero
	task automatic rd(input logic [7:0] ad, input logic mode, input logic [7:0] e);
		@(negedge clk_sys);
		sfrAddr = ad;
		if (mode) t0ModeRdInstr = 1'b1;
		else sfrRdEn = 1'b1;
		@(negedge clk_sys);
		sfrRdEn = 1'b0;
		t0ModeRdInstr = 1'b0;
		chk("read data", 64'(e), 64'(sfrRdData_r));
		@(negedge clk_sys);
		chk("read idle", 64'h0, 64'(sfrRdData_r));
	endtask

	// Register-driven outputs other than sfrRdData_r, prescaleLog2_r and timer0Source_r against the shadow copy at once
	task automatic check_outs;
		logic [13:0] mp;
		logic [7:0]  e, f;
		e = sh[5'h18];
		f = sh[5'h1B];
		mp = 14'h0000;
		if (f[7] && f[3:0] <= 4'hD) mp[f[3:0]] = 1'b1;
		chk("outputs", {sh[5'h16], sh[5'h17][5:0], e[5:0], e[5] ? e[3:2] : 2'h0,
			e[4] ? e[1:0] : 2'h0, sh[5'h19][5:4], sh[5'h19][7:6], sh[5'h1C][5:4],
			sh[5'h1C][3:0], sh[5'h19][3:0], sh[5'h1A][7], f[7], mp, sh[5'h1F][4],
			sh[5'h1F][4] & sh[5'h1F][0], shT0},
			{portbAnalogOnly_r, portaAnalogOnly_r, trim_r, extIrqPinRoute_r,
			extIrq1EdgeSel_r, extIrq0EdgeSel_r, extIrq1Edges_r, extIrq0Edges_r,
			timer1Reload98_r, timer2Reload98_r, timer3Reload98_r, dutyUpper_r,
			comparatorOn_r, freqMeasureOn_r, measPadOneHot_r, timer3UnderflowFlag_r,
			timer3IrqReq_r, t0Mode_r});
	endtask

	task automatic wrs(input logic [7:0] ad, input logic [7:0] d);
		wr(ad, d, 1'b0);
		sh[ad[4:0]] = d & mask(ad);
		check_outs();
		rd(ad, 1'b0, rdExp(ad));
	endtask

	task automatic pulse_uf;
		@(negedge clk_sys);
		timer3Underflow = 1'b1;
		@(negedge clk_sys);
		timer3Underflow = 1'b0;
		sh[5'h1F][4] = 1'b1;
		repeat (2) @(negedge clk_sys);
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		{reset, sfrWrEn, sfrRdEn, t0ModeWrInstr, t0ModeRdInstr} = 5'h10;
		{timer3Underflow, wdtIrqMode, timer1Count98, timer2Count98} = 6'h00;
		{sfrAddr, sfrWrData, timer3Count98} = 18'h00000;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		for (int i = 0; i < 32; i++) sh[i] = 8'h00;
		sh[5'h18] = 8'h05;
		shT0 = 8'h3F;
		// Reset values; high bytes hold no reset value and are skipped
		for (a = 8'h16; a <= 8'h1F; a++) if (a != 8'h19 && a != 8'h1C) rd(a, 1'b0, rdExp(a));
		rd(8'h00, 1'b1, 8'h3F);
		wr(8'h1C, 8'h00, 1'b0);
		wrs(8'h19, 8'h00);
		wrs(8'h1C, 8'h00);
		// Every pattern through every address, unmapped ones included
		foreach (pat[i]) begin
			{timer1Count98, timer2Count98} = pat[i][3:0];
			timer3Count98 = ~pat[i][1:0];
			for (a = 8'h16; a <= 8'h1F; a++) wrs(a, pat[i]);
		end
		// Sticky underflow flag and gated request
		wrs(8'h1F, 8'h01);
		pulse_uf();
		check_outs();
		repeat (6) @(negedge clk_sys);
		check_outs();
		wrs(8'h1F, 8'h00);
		pulse_uf();
		check_outs();
		wrs(8'h1F, 8'h01);
		// Mode register: every value, prescaler set before anything relies on it
		for (int k = 0; k < 256; k++) begin
			wdtIrqMode = k[6];
			wr(8'h00, 8'(k), 1'b1);
			shT0 = 8'(k);
			lg = {1'b0, shT0[2:0]} + ((shT0[3] && !wdtIrqMode) ? 4'h0 : 4'h1);
			src = !shT0[5] ? SRC_INSTR : (shT0[7] ? SRC_LOW_OSC : SRC_EXT_PIN);
			chk("prescale", 64'(lg), 64'(prescaleLog2_r));
			chk("source", 64'(src), 64'(timer0Source_r));
			check_outs();
			rd(8'h00, 1'b1, shT0);
		end
		end_of_test();
	end

	// Hang guard: the sequence needs a few thousand cycles
	initial begin
		#2000000;
		fails++;
		end_of_test();
	end
endmodule
